// *** rtl/port_forwarding_classification_regs.sv ***
/*
  Forwarding-group, destination portmap, per-port priority and filter
  enables, and packet identification options of a six-port switch.
  Assumes the management side drives a synchronous word-wide register
  port on the core clock; one access per cycle.
*/
// Summary of operation
// - Bits 8,7,6,4,2,0 of every register are writable group flags for ports 5..0.
// - Group flags reset to one, and bits 5,3,1 always read zero.
// - Offset 0x19 holds the unicast portmap in 14:9, reset all ones, bit 15 fixed.
// - Offset 0x1a holds the broadcast portmap in 14:9, reset all ones.
// - Offset 0x1b holds the multicast portmap in 14:9, with a loosely printed reset.
// - Offset 0x1c holds the reserved-address portmap in 14:9, reset all ones.
// - Bit 15 of 0x1d picks the MLD header value, 01 when clear and 3a when set.
// - Bits 14 and 9 of 0x1d switch off VLAN-after-SNAP and SNAP recognition.
// - Bit 13 of 0x1d switches off IPv6-in-PPPoE recognition.
// - Bits 12 and 10 of 0x1d switch off IP-in-PPPoE after SNAP and generally.
// - With bit 11 of 0x1d clear, IP ethertype with version 6 counts as IPv6.
// - Bits 14:9 of 0x1e enable tag priority per port, reset all ones.
// - Bits 14:9 of the service register enable TOS or class priority per port.
// - Bits 14:9 of the force-untag register enable forced untagging per port.
// - Bits 14:9 of the ingress filter register enable filtering per port.
`timescale 1ns/1ps
`default_nettype none
module port_forwarding_classification_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire fwd_class_pkg::reg_req_s req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Forwarding group membership, one row per register
  output logic [8:0][5:0] fwd_group,
  // Destination portmaps
  output logic [5:0] unicast_map,
  output logic [5:0] broadcast_map,
  output logic [5:0] multicast_map,
  output logic [5:0] reserved_addr_map,
  // Per-port enables
  output logic [5:0] tag_prio_en,
  output logic [5:0] service_prio_en,
  output logic [5:0] force_untag_en,
  output logic [5:0] ingress_filter_en,
  // Packet identification options, high means recognise
  output logic [7:0] mld_header,
  output logic vlan_after_snap_en,
  output logic ipv6_in_pppoe_en,
  output logic ip_pppoe_after_snap_en,
  output logic ip_in_pppoe_en,
  output logic snap_en,
  // Frame classification
  input wire fwd_class_pkg::frame_hdr_s frame,
  output logic class_valid,
  output logic frame_is_ipv4,
  output logic frame_is_ipv6
);
  import fwd_class_pkg::*;

  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0][15:0] reg_value;
  logic [NUM_REGS-1:0][15:0] read_term;
  logic [15:0] next_rd_data;
  logic [15:0] pkt_opts;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      localparam logic [15:0] MASK = (gi == IDX_PKT_ID) ? MASK_PKT_ID : MASK_PORTMAP;
      assign hit[gi] = req.addr == REG_OFFSETS[gi];
      // Masked write keeps fixed bits constant
      field_reg #(
        .RESET_VALUE(REG_RESET),
        .WRITE_MASK(MASK)
      ) u_reg (
        .clk(clk),
        .reset(reset),
        .wr_en(req.wr && hit[gi]),
        .wdata(req.wdata),
        .value(reg_value[gi])
      );
      // Group flags gathered port 5 down to port 0
      assign fwd_group[gi] = {reg_value[gi][8], reg_value[gi][7], reg_value[gi][6],
                              reg_value[gi][4], reg_value[gi][2], reg_value[gi][0]};
      assign read_term[gi] = hit[gi] ? reg_value[gi] : 16'h0000;
    end
  endgenerate

  // Unmapped addresses read zero
  always_comb begin
    next_rd_data = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      next_rd_data = next_rd_data | read_term[i];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Per-port fields, bit 9 plus n is port n
  assign unicast_map = reg_value[IDX_UNICAST][PORT_FIELD_HI:PORT_FIELD_LO];
  assign broadcast_map = reg_value[IDX_BROADCAST][PORT_FIELD_HI:PORT_FIELD_LO];
  assign multicast_map = reg_value[IDX_MULTICAST][PORT_FIELD_HI:PORT_FIELD_LO];
  assign reserved_addr_map = reg_value[IDX_RESERVED_ADDR][PORT_FIELD_HI:PORT_FIELD_LO];
  assign tag_prio_en = reg_value[IDX_TAG_PRIO][PORT_FIELD_HI:PORT_FIELD_LO];
  assign service_prio_en = reg_value[IDX_SERVICE_PRIO][PORT_FIELD_HI:PORT_FIELD_LO];
  assign force_untag_en = reg_value[IDX_FORCE_UNTAG][PORT_FIELD_HI:PORT_FIELD_LO];
  assign ingress_filter_en = reg_value[IDX_INGRESS_FILTER][PORT_FIELD_HI:PORT_FIELD_LO];

  // Option bits 14:9 are disables and bit 15 selects the MLD header; other outputs are recognise enables
  assign pkt_opts = reg_value[IDX_PKT_ID];
  assign mld_header = pkt_opts[BIT_MLD_SEL] ? MLD_HDR_SET : MLD_HDR_CLEAR;
  assign vlan_after_snap_en = !pkt_opts[BIT_NO_VLAN_AFTER_SNAP];
  assign snap_en = !pkt_opts[BIT_NO_SNAP];
  assign ipv6_in_pppoe_en = !pkt_opts[BIT_NO_IPV6_IN_PPPOE];
  assign ip_pppoe_after_snap_en = !pkt_opts[BIT_NO_IP_PPPOE_SNAP];
  assign ip_in_pppoe_en = !pkt_opts[BIT_NO_IP_IN_PPPOE];

  frame_classifier u_class (
    .clk(clk),
    .reset(reset),
    .frame(frame),
    .ipv6_by_version_off(pkt_opts[BIT_NO_IPV6_BY_VERSION]),
    .class_valid(class_valid),
    .is_ipv4(frame_is_ipv4),
    .is_ipv6(frame_is_ipv6)
  );

  // Checks
  logic any_hit;
  logic [5:0] field_reset;
  logic [5:0] group_reset;
  assign any_hit = |hit;
  // Reset images of one per-port field and one group row
  assign field_reset = REG_RESET[PORT_FIELD_HI:PORT_FIELD_LO];
  assign group_reset = {REG_RESET[8], REG_RESET[7], REG_RESET[6], REG_RESET[4], REG_RESET[2],
                        REG_RESET[0]};

  a_group_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_RESERVED_ADDR) |=>
      fwd_group[IDX_RESERVED_ADDR] == {$past(req.wdata[8]), $past(req.wdata[7]),
        $past(req.wdata[6]), $past(req.wdata[4]), $past(req.wdata[2]), $past(req.wdata[0])})
    else $error("group flags did not follow write");

  a_gap_bits_zero: assert property (@(posedge clk) disable iff (reset)
    (req.rd && any_hit) |=> (rd_valid && rd_data[5] == 1'b0 && rd_data[3] == 1'b0
      && rd_data[1] == 1'b0))
    else $error("reserved gap bits read nonzero");

  a_unicast_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_UNICAST) |=> unicast_map == $past(req.wdata[14:9]))
    else $error("unicast map did not follow write");

  a_fixed_top_bit: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == OFF_UNICAST) |=> rd_data[15] == 1'b1)
    else $error("fixed bit 15 changed");

  a_broadcast_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_BROADCAST) |=> broadcast_map == $past(req.wdata[14:9]))
    else $error("broadcast map did not follow write");

  a_multicast_hold: assert property (@(posedge clk) disable iff (reset)
    !(req.wr && req.addr == OFF_MULTICAST) |=> $stable(multicast_map))
    else $error("multicast map changed without write");

  a_reserved_map: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_RESERVED_ADDR) |=>
      reserved_addr_map == $past(req.wdata[14:9]))
    else $error("reserved map did not follow write");

  a_mld_value: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID) |=>
      mld_header == ($past(req.wdata[BIT_MLD_SEL]) ? MLD_HDR_SET : MLD_HDR_CLEAR))
    else $error("mld header wrong after write");

  a_snap_disable: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID && req.wdata[9]) |=> !snap_en)
    else $error("snap recognised while disabled");

  a_pppoe_ipv6: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID) |=> ipv6_in_pppoe_en == !$past(req.wdata[13]))
    else $error("ipv6 in pppoe enable wrong");

  a_ipv6_class: assert property (@(posedge clk) disable iff (reset)
    (frame.valid && frame.ethertype == ETHERTYPE_IP && frame.ip_version == IP_VERSION_6)
      |=> (class_valid && frame_is_ipv6 == !$past(pkt_opts[BIT_NO_IPV6_BY_VERSION])))
    else $error("ipv6 classification wrong");

  a_ingress_filter: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_INGRESS_FILTER) |=>
      ingress_filter_en == $past(req.wdata[PORT_FIELD_HI:PORT_FIELD_LO]))
    else $error("ingress filter field lost");

  a_multicast_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_MULTICAST) |=>
      multicast_map == $past(req.wdata[PORT_FIELD_HI:PORT_FIELD_LO]))
    else $error("multicast map did not follow write");

  a_tag_prio_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_TAG_PRIO) |=>
      tag_prio_en == $past(req.wdata[PORT_FIELD_HI:PORT_FIELD_LO]))
    else $error("tag priority enables did not follow write");

  a_service_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_SERVICE_PRIO) |=>
      service_prio_en == $past(req.wdata[PORT_FIELD_HI:PORT_FIELD_LO]))
    else $error("service priority enables did not follow write");

  a_untag_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_FORCE_UNTAG) |=>
      force_untag_en == $past(req.wdata[PORT_FIELD_HI:PORT_FIELD_LO]))
    else $error("force untag enables did not follow write");

  a_vlan_snap: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID) |=>
      vlan_after_snap_en == !$past(req.wdata[BIT_NO_VLAN_AFTER_SNAP]))
    else $error("vlan after snap enable wrong");

  a_snap_enable: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID && !req.wdata[BIT_NO_SNAP]) |=> snap_en)
    else $error("snap not recognised while enabled");

  a_pppoe_snap: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID) |=>
      ip_pppoe_after_snap_en == !$past(req.wdata[BIT_NO_IP_PPPOE_SNAP]))
    else $error("ip in pppoe after snap enable wrong");

  a_pppoe_ip: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == OFF_PKT_ID) |=>
      ip_in_pppoe_en == !$past(req.wdata[BIT_NO_IP_IN_PPPOE]))
    else $error("ip in pppoe enable wrong");

  a_ipv4_class: assert property (@(posedge clk) disable iff (reset)
    (frame.valid && frame.ethertype == ETHERTYPE_IP && frame.ip_version == IP_VERSION_4)
      |=> (class_valid && frame_is_ipv4 && !frame_is_ipv6))
    else $error("ipv4 classification wrong");

  a_other_type: assert property (@(posedge clk) disable iff (reset)
    (frame.valid && frame.ethertype != ETHERTYPE_IP) |=>
      (!frame_is_ipv4 && !frame_is_ipv6))
    else $error("non ip frame classified as ip");

  a_class_pulse: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> class_valid == $past(frame.valid))
    else $error("class valid not one cycle after frame valid");

  a_class_hold: assert property (@(posedge clk) disable iff (reset)
    !frame.valid |=> ($stable(frame_is_ipv4) && $stable(frame_is_ipv6)))
    else $error("classification changed without a frame");

  a_read_pulse: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> rd_valid == $past(req.rd))
    else $error("read valid not one cycle after read strobe");

  a_read_hold: assert property (@(posedge clk) disable iff (reset)
    !req.rd |=> $stable(rd_data))
    else $error("read data changed without a read");

  a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
    (req.rd && !any_hit) |=> rd_data == 16'h0000)
    else $error("unmapped offset read nonzero");

  a_fixed_top_all: assert property (@(posedge clk) disable iff (reset)
    (req.rd && any_hit && req.addr != OFF_PKT_ID) |=> rd_data[15] == 1'b1)
    else $error("fixed bit 15 read wrong");

  a_reset_maps: assert property (@(posedge clk)
    $fell(reset) |-> (unicast_map == field_reset && broadcast_map == field_reset
      && multicast_map == field_reset && reserved_addr_map == field_reset))
    else $error("portmap not at reset value");

  a_reset_enables: assert property (@(posedge clk)
    $fell(reset) |-> (tag_prio_en == field_reset && service_prio_en == field_reset
      && force_untag_en == field_reset && ingress_filter_en == field_reset))
    else $error("port enables not at reset value");

  a_reset_options: assert property (@(posedge clk)
    $fell(reset) |-> (mld_header == MLD_HDR_SET && !vlan_after_snap_en && !ipv6_in_pppoe_en
      && !ip_pppoe_after_snap_en && !ip_in_pppoe_en && !snap_en))
    else $error("identification options not at reset value");

  a_reset_groups: assert property (@(posedge clk)
    $fell(reset) |-> fwd_group == {NUM_REGS{group_reset}})
    else $error("group flags not at reset value");

  a_reset_read: assert property (@(posedge clk)
    $fell(reset) |-> (!rd_valid && !class_valid && rd_data == 16'h0000))
    else $error("read or class outputs not cleared by reset");

  // Per-register checks on group flags, gap bits and untouched registers
  for (gi = 0; gi < NUM_REGS; gi++) begin : g_chk
    a_row_group: assert property (@(posedge clk) disable iff (reset)
      (req.wr && hit[gi]) |=> fwd_group[gi] == {$past(req.wdata[8]), $past(req.wdata[7]),
        $past(req.wdata[6]), $past(req.wdata[4]), $past(req.wdata[2]), $past(req.wdata[0])})
      else $error("row group flags did not follow write");
    a_row_hold: assert property (@(posedge clk) disable iff (reset)
      !(req.wr && hit[gi]) |=> $stable(reg_value[gi]))
      else $error("register changed without a write");
    a_row_gaps: assert property (@(posedge clk) disable iff (reset)
      (req.wr && hit[gi]) |=> {reg_value[gi][5], reg_value[gi][3], reg_value[gi][1]} == 3'b000)
      else $error("gap bits took written value");
  end

endmodule
`default_nettype wire

// *** rtl/fwd_class_pkg.sv ***
/*
  Shared constants and carriers for the forwarding and classification
  register bank: offsets, reset values, write masks, field positions.
  Assumes a single core clock domain and a word-wide register port.
*/
package fwd_class_pkg;

  localparam int NUM_REGS = 9;
  localparam int NUM_PORTS = 6;

  // Register indices into the bank
  localparam int IDX_UNICAST = 0;
  localparam int IDX_BROADCAST = 1;
  localparam int IDX_MULTICAST = 2;
  localparam int IDX_RESERVED_ADDR = 3;
  localparam int IDX_PKT_ID = 4;
  localparam int IDX_TAG_PRIO = 5;
  localparam int IDX_SERVICE_PRIO = 6;
  localparam int IDX_FORCE_UNTAG = 7;
  localparam int IDX_INGRESS_FILTER = 8;

  localparam logic [7:0] OFF_UNICAST = 8'h19;
  localparam logic [7:0] OFF_BROADCAST = 8'h1a;
  localparam logic [7:0] OFF_MULTICAST = 8'h1b;
  localparam logic [7:0] OFF_RESERVED_ADDR = 8'h1c;
  localparam logic [7:0] OFF_PKT_ID = 8'h1d;
  localparam logic [7:0] OFF_TAG_PRIO = 8'h1e;
  localparam logic [7:0] OFF_SERVICE_PRIO = 8'h1f;
  localparam logic [7:0] OFF_FORCE_UNTAG = 8'h20;
  localparam logic [7:0] OFF_INGRESS_FILTER = 8'h21;

  localparam logic [NUM_REGS-1:0][7:0] REG_OFFSETS = {
    OFF_INGRESS_FILTER, OFF_FORCE_UNTAG, OFF_SERVICE_PRIO, OFF_TAG_PRIO,
    OFF_PKT_ID, OFF_RESERVED_ADDR, OFF_MULTICAST, OFF_BROADCAST, OFF_UNICAST};

  // Bit 15 reads one, field and group bits one, reserved group gaps zero
  localparam logic [15:0] REG_RESET = 16'hffd5;
  localparam logic [15:0] MASK_PORTMAP = 16'h7fd5;
  localparam logic [15:0] MASK_PKT_ID = 16'hffd5;

  localparam int PORT_FIELD_LO = 9;
  localparam int PORT_FIELD_HI = 14;

  localparam int BIT_MLD_SEL = 15;
  localparam int BIT_NO_VLAN_AFTER_SNAP = 14;
  localparam int BIT_NO_IPV6_IN_PPPOE = 13;
  localparam int BIT_NO_IP_PPPOE_SNAP = 12;
  localparam int BIT_NO_IPV6_BY_VERSION = 11;
  localparam int BIT_NO_IP_IN_PPPOE = 10;
  localparam int BIT_NO_SNAP = 9;

  localparam logic [7:0] MLD_HDR_CLEAR = 8'h01;
  localparam logic [7:0] MLD_HDR_SET = 8'h3a;
  localparam logic [15:0] ETHERTYPE_IP = 16'h0800;
  localparam logic [3:0] IP_VERSION_4 = 4'h4;
  localparam logic [3:0] IP_VERSION_6 = 4'h6;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] ethertype;
    logic [3:0] ip_version;
  } frame_hdr_s;

endpackage

// *** rtl/field_reg.sv ***
/*
  One 16-bit configuration register with a per-bit write mask.
  Masked-off bits are constant and read back their reset value.
*/
`timescale 1ns/1ps
`default_nettype none
module field_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hffff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  // Current contents
  output logic [15:0] value
);

  logic [15:0] q;
  wire logic [15:0] next_q = wr_en ? (wdata & WRITE_MASK) : q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= RESET_VALUE & WRITE_MASK;
    end else begin
      q <= next_q;
    end
  end

  assign value = q | (RESET_VALUE & ~WRITE_MASK);

endmodule
`default_nettype wire

// *** rtl/frame_classifier.sv ***
/*
  Registers an IP version classification of a received header.
  Assumes the header fields are valid in the cycle frame.valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_classifier (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Header in
  input wire fwd_class_pkg::frame_hdr_s frame,
  input wire logic ipv6_by_version_off,
  // Result
  output logic class_valid,
  output logic is_ipv4,
  output logic is_ipv6
);
  import fwd_class_pkg::*;

  wire logic ip_type = frame.ethertype == ETHERTYPE_IP;
  wire logic next_ipv4 = ip_type && frame.ip_version == IP_VERSION_4;
  wire logic next_ipv6 = ip_type && frame.ip_version == IP_VERSION_6 && !ipv6_by_version_off;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      class_valid <= 1'b0;
      is_ipv4 <= 1'b0;
      is_ipv6 <= 1'b0;
    end else begin
      class_valid <= frame.valid;
      if (frame.valid) begin
        is_ipv4 <= next_ipv4;
        is_ipv6 <= next_ipv6;
      end
    end
  end

endmodule
`default_nettype wire

// *** test/mgmt_host_model.sv ***
/*
  Management side model: drives the word-wide register port.
  Assumes calls start just after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output var fwd_class_pkg::reg_req_s req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  import fwd_class_pkg::*;
  initial req = '{1'b0, 1'b0, 8'h00, 16'h0000};
  // One strobe cycle, then one idle cycle with stale lines inverted
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [15:0] d, output logic v, output logic [15:0] q);
    req = '{w, r, a, d};
    @(posedge clk) #1;
    v = rd_valid;
    q = rd_data;
    req = '{1'b0, 1'b0, ~a, ~d};
    @(posedge clk) #1;
  endtask
endmodule
`default_nettype wire

// *** test/tb_port_forwarding_classification_regs.sv ***
/*
  Self-checking bench for the forwarding and classification registers.
  Assumes the management model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_port_forwarding_classification_regs;
  import fwd_class_pkg::*;
  logic clk, reset, rd_valid, class_valid, frame_is_ipv4, frame_is_ipv6, gv;
  reg_req_s req;
  frame_hdr_s frame;
  logic [15:0] rd_data, got;
  logic [8:0][5:0] fwd_group, fld;
  logic [5:0] unicast_map, broadcast_map, multicast_map, reserved_addr_map;
  logic [5:0] tag_prio_en, service_prio_en, force_untag_en, ingress_filter_en;
  logic [7:0] mld_header;
  logic vlan_after_snap_en, ipv6_in_pppoe_en, ip_pppoe_after_snap_en, ip_in_pppoe_en, snap_en;
  int err_count = 0;
  int total_checks = 0;
  // Offset, write data, read back
  localparam logic [39:0] ROWS [10] = '{40'h19_0000_8000, 40'h1a_ffff_ffd5,
    40'h1b_2a55_aa55, 40'h1c_5400_d400, 40'h1d_0000_0000, 40'h1e_1234_9214,
    40'h1f_7fff_ffd5, 40'h20_8155_8155, 40'h21_02aa_8280, 40'h22_ffff_0000};
  assign fld = {ingress_filter_en, force_untag_en, service_prio_en, tag_prio_en, 6'h00,
                reserved_addr_map, multicast_map, broadcast_map, unicast_map};
  port_forwarding_classification_regs port_forwarding_classification_regs_inst (
    .clk, .reset, .req, .rd_data, .rd_valid, .fwd_group, .unicast_map, .broadcast_map,
    .multicast_map, .reserved_addr_map, .tag_prio_en, .service_prio_en, .force_untag_en,
    .ingress_filter_en, .mld_header, .vlan_after_snap_en, .ipv6_in_pppoe_en,
    .ip_pppoe_after_snap_en, .ip_in_pppoe_en, .snap_en, .frame, .class_valid,
    .frame_is_ipv4, .frame_is_ipv6);
  mgmt_host_model mgmt_host_model_inst (.clk, .req, .rd_data, .rd_valid);

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] w);
    mgmt_host_model_inst.access(1'b1, 1'b0, a, w, gv, got);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    mgmt_host_model_inst.access(1'b0, 1'b1, a, 16'h0000, gv, got);
    check("rd_valid", {15'h0, gv}, 16'h0001);
    check("rd_data", got, exp);
  endtask
  task automatic chk_pkt(logic [15:0] w);
    check("mld_header", {8'h00, mld_header}, w[15] ? 16'h003a : 16'h0001);
    check("recognise", {11'h0, vlan_after_snap_en, ipv6_in_pppoe_en, ip_pppoe_after_snap_en,
          ip_in_pppoe_en, snap_en}, {11'h0, ~{w[14], w[13], w[12], w[10], w[9]}});
  endtask
  task automatic send(logic [15:0] et, logic [3:0] v, logic e4, logic e6);
    frame = '{1'b1, et, v};
    @(posedge clk) #1;
    check("class_valid", {15'h0, class_valid}, 16'h0001);
    check("ipv4", {15'h0, frame_is_ipv4}, {15'h0, e4});
    check("ipv6", {15'h0, frame_is_ipv6}, {15'h0, e6});
  endtask
  task automatic reset_test;
    for (int i = 0; i < 9; i++) begin
      rd(REG_OFFSETS[i], 16'hffd5);
    end
    chk_pkt(16'hffd5);
    $display("test reset done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    frame = '{1'b0, 16'h0000, 4'h0};
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    reset_test();
    for (int i = 0; i < 10; i++) begin
      wr(ROWS[i][39:32], ROWS[i][31:16]);
      rd(ROWS[i][39:32], ROWS[i][15:0]);
      if (i < 9) begin
        got = ROWS[i][31:16];
        check("group", {10'h0, fwd_group[i]}, {10'h0, got[8:6], got[4], got[2], got[0]});
        if (i != 4) check("field", {10'h0, fld[i]}, {10'h0, got[14:9]});
      end
    end
    $display("test table done");
    chk_pkt(16'h0000);
    for (int b = 9; b < 16; b++) begin
      wr(OFF_PKT_ID, 16'h0001 << b);
      chk_pkt(16'h0001 << b);
    end
    wr(OFF_PKT_ID, 16'h0000);
    send(16'h0800, 4'h6, 1'b0, 1'b1);
    send(16'h0800, 4'h4, 1'b1, 1'b0);
    send(16'h86dd, 4'h6, 1'b0, 1'b0);
    frame.valid = 1'b0;
    wr(OFF_PKT_ID, 16'h0800);
    send(16'h0800, 4'h6, 1'b0, 1'b0);
    frame.valid = 1'b0;
    $display("test classify done");
    mgmt_host_model_inst.access(1'b1, 1'b1, OFF_UNICAST, 16'h7fff, gv, got);
    check("old read", got, 16'h8000);
    rd(OFF_UNICAST, 16'hffd5);
    $display("test same cycle done");
    reset = 1'b1;
    @(posedge clk) #1;
    reset = 1'b0;
    reset_test();
    complete_run();
  end
endmodule
`default_nettype wire
